/* tb_top.sv */
// Purpose: self-checking bench for the negative-sequence protection block
// Assumes: heating 100 x 2 per tick, trip level 500, cap 1000, cooling 250
// Notes:   SQ_SHIFT lowered so that a moderate wave clears the clamp
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst = 1'b1, blk = 1'b0, clr = 1'b0, cfg = 1'b1;
    unb_pkg::unb_mode_e mode = unb_pkg::UNB_MODE_ON;
    logic [31:0] perm = 32'h0, high = 32'hFFFFFFFF, kFac = 32'hFA, nsq;
    logic [23:0] wDly = 24'h3, hDly = 24'h2, cool = 24'h2;
    logic signed [15:0] amp = 16'sh0, sa, sb, sc;
    logic sv, act, pPk, hPk, warn, thTr, hTr, cmd, done;
    int miscompares = 0, compares = 0;
    always #25 clk = ~clk;
    unb_phase_source u_unb_phase_source (.clk(clk), .rst(rst), .amp(amp), .sampleValid(sv),
        .sampleA(sa), .sampleB(sb), .sampleC(sc), .cycleDone(done));
    unb_negseq_prot #(.SQ_SHIFT(12)) u_unb_negseq_prot (.clk(clk), .rst(rst), .sampleValid(sv),
        .sampleA(sa), .sampleB(sb), .sampleC(sc), .functionBlockInput(blk),
        .thermalClearInput(clr), .configEnabled(cfg), .functionMode(mode),
        .permissibleUnbalanceThreshold(perm), .highUnbalanceThreshold(high),
        .warnDelay(wDly), .highStageDelay(hDly), .asymmetryFactor(kFac),
        .coolDownTime(cool), .functionActive(act), .permPickup(pPk), .highPickup(hPk),
        .unbalanceWarningFlag(warn), .thermalTrip(thTr), .highStageTrip(hTr),
        .tripCommand(cmd), .negSeqSquared(nsq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // wait n ticks, outputs land two clocks after the twelfth sample
    task automatic step(input int n);
        repeat (n) @(posedge clk iff done === 1'b1);
        repeat (3) @(posedge clk);
        #1;
    endtask : step
    // block while changing the mode, release on a cycle edge
    task automatic t_block(input unb_pkg::unb_mode_e m);
        @(posedge clk);
        blk <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk(pPk | warn | hTr | thTr, 1'b0);
        @(posedge clk iff done === 1'b1);
        blk <= 1'b0;
        // mode moves only while the synced block still holds the trips down
        mode <= m;
        step(1);
        chk(warn, 1'b0);
    endtask : t_block
    task automatic t_warn;
        step(1);
        chk(nsq, 32'h0);
        chk(act, 1'b1);
        @(posedge clk iff done === 1'b1);
        amp <= 16'sh3E80;
        step(2);
        chk(pPk, 1'b1);
        chk(warn, 1'b0);
        step(1);
        chk(warn, 1'b1);
        chk(nsq > 32'h64, 1'b1);
    endtask : t_warn
    task automatic t_high;
        // settings act on the very next tick, so change them just after one
        @(posedge clk);
        high <= 32'h0;
        step(1);
        chk(hTr, 1'b0);
        chk(hPk, 1'b1);
        step(1);
        chk(cmd & hTr, 1'b1);
        t_block(unb_pkg::UNB_MODE_TRIP_INHIBIT);
        step(1);
        chk({hTr, cmd}, 2'h2);
        @(posedge clk);
        high <= 32'hFFFFFFFF;
        perm <= 32'h1;
    endtask : t_high
    task automatic t_thermal;
        t_block(unb_pkg::UNB_MODE_ON);
        step(1);
        chk({pPk, thTr}, 2'h2);
        step(2);
        chk(cmd & thTr, 1'b1);
        step(3);
        @(posedge clk iff done === 1'b1);
        amp <= 16'sh0;
        step(2);
        chk({pPk, thTr}, 2'h0);
        @(posedge clk iff done === 1'b1);
        amp <= 16'sh3E80;
        step(1);
        chk(thTr, 1'b0);
        step(1);
        chk(thTr, 1'b1);
    endtask : t_thermal
    task automatic t_clear_off;
        @(posedge clk iff done === 1'b1);
        clr <= 1'b1;
        step(2);
        chk({pPk, warn, thTr}, 3'h6);
        @(posedge clk);
        clr <= 1'b0;
        mode <= unb_pkg::UNB_MODE_OFF;
        step(1);
        chk({act, pPk}, 2'h0);
        @(posedge clk);
        mode <= unb_pkg::UNB_MODE_ON;
        cfg <= 1'b0;
        step(1);
        chk({act, pPk}, 2'h0);
    endtask : t_clear_off
    task automatic test_done;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_warn();
        t_block(unb_pkg::UNB_MODE_ON);
        t_high();
        t_thermal();
        t_clear_off();
        test_done();
    end
    // hang guard, far beyond the few hundred clocks of the run
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        test_done();
    end
endmodule : tb_top
`default_nettype wire

/* unb_negseq_prot.sv */
// Purpose: negative-sequence (unbalanced load) protection with warning,
//          thermal and definite-time high-set stages
// Assumes: phase samples arrive from same-clock acquisition logic; block and
//          thermal-clear inputs are asynchronous binary inputs
// Notes:   one protection tick per power cycle; delays are counted in ticks
`timescale 1ns/1ps
`default_nettype none

module unb_negseq_prot #(
    parameter int SQ_SHIFT = 15
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // phase samples from acquisition
    input  wire logic                          sampleValid,
    input  wire logic signed [unb_pkg::SAMPLE_W-1:0] sampleA,
    input  wire logic signed [unb_pkg::SAMPLE_W-1:0] sampleB,
    input  wire logic signed [unb_pkg::SAMPLE_W-1:0] sampleC,
    // binary inputs (asynchronous)
    input  wire logic                          functionBlockInput,
    input  wire logic                          thermalClearInput,
    // configuration and settings
    input  wire logic                          configEnabled,
    input  wire unb_pkg::unb_mode_e            functionMode,
    input  wire logic [unb_pkg::SQ_W-1:0]      permissibleUnbalanceThreshold,
    input  wire logic [unb_pkg::SQ_W-1:0]      highUnbalanceThreshold,
    input  wire logic [unb_pkg::TICK_W-1:0]    warnDelay,
    input  wire logic [unb_pkg::TICK_W-1:0]    highStageDelay,
    input  wire logic [unb_pkg::SQ_W-1:0]      asymmetryFactor,
    input  wire logic [unb_pkg::TICK_W-1:0]    coolDownTime,
    // indications and commands
    output logic                               functionActive,
    output logic                               permPickup,
    output logic                               highPickup,
    output logic                               unbalanceWarningFlag,
    output logic                               thermalTrip,
    output logic                               highStageTrip,
    output logic                               tripCommand,
    output logic [unb_pkg::SQ_W-1:0]           negSeqSquared
);

    localparam int DFT_W  = unb_pkg::SAMPLE_W + unb_pkg::COEF_W + 4;
    localparam int SEQ_W  = DFT_W + 3;
    localparam int PROD_W = unb_pkg::SQ_W + unb_pkg::TICK_W;

    // binary input synchronisers
    logic blkMeta_q, blkSync_q, clrMeta_q, clrSync_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            blkMeta_q <= 1'b0;
            blkSync_q <= 1'b0;
            clrMeta_q <= 1'b0;
            clrSync_q <= 1'b0;
        end else begin
            blkMeta_q <= functionBlockInput;
            blkSync_q <= blkMeta_q;
            clrMeta_q <= thermalClearInput;
            clrSync_q <= clrMeta_q;
        end
    end

    // sample index within the power cycle
    logic [unb_pkg::IDX_W-1:0] idx_q;
    wire lastSample = sampleValid && (idx_q == unb_pkg::LAST_SAMPLE_IDX);
    always_ff @(posedge clk) begin
        if (rst) idx_q <= unb_pkg::FIRST_SAMPLE_IDX;
        else if (lastSample) idx_q <= unb_pkg::FIRST_SAMPLE_IDX;
        else if (sampleValid) idx_q <= idx_q + 4'h1;
    end

    // one-cycle full-cycle DFT per phase; phasors latched at cycle end
    logic signed [unb_pkg::SAMPLE_W-1:0] samp [3];
    logic signed [DFT_W-1:0]             phRe [3];
    logic signed [DFT_W-1:0]             phIm [3];
    assign samp[0] = sampleA;
    assign samp[1] = sampleB;
    assign samp[2] = sampleC;
    for (genvar p = 0; p < 3; p++) begin : g_dft
        logic signed [DFT_W-1:0] sumRe_q, sumIm_q, latRe_q, latIm_q;
        wire signed [DFT_W-1:0] termRe = DFT_W'(samp[p] * unb_pkg::COS_TAB[idx_q]);
        wire signed [DFT_W-1:0] termIm = DFT_W'(samp[p] * unb_pkg::SIN_TAB[idx_q]);
        wire signed [DFT_W-1:0] newRe  = sumRe_q + termRe;
        wire signed [DFT_W-1:0] newIm  = sumIm_q - termIm;
        always_ff @(posedge clk) begin
            if (rst) begin
                sumRe_q <= '0;
                sumIm_q <= '0;
                latRe_q <= '0;
                latIm_q <= '0;
            end else if (lastSample) begin
                sumRe_q <= '0;
                sumIm_q <= '0;
                latRe_q <= newRe;
                latIm_q <= newIm;
            end else if (sampleValid) begin
                sumRe_q <= newRe;
                sumIm_q <= newIm;
            end
        end
        assign phRe[p] = latRe_q;
        assign phIm[p] = latIm_q;
    end

    // protection tick one cycle after the phasors are latched
    logic tick_q;
    always_ff @(posedge clk) begin
        if (rst) tick_q <= 1'b0;
        else tick_q <= lastSample;
    end

    // 3*I2 = Ia + a^2*Ib + a*Ic
    wire signed [SEQ_W-1:0] difIm = SEQ_W'(phIm[1]) - SEQ_W'(phIm[2]);
    wire signed [SEQ_W-1:0] difRe = SEQ_W'(phRe[2]) - SEQ_W'(phRe[1]);
    wire signed [SEQ_W+8:0] rotRe = difIm * unb_pkg::ROT_IM_Q8;
    wire signed [SEQ_W+8:0] rotIm = difRe * unb_pkg::ROT_IM_Q8;
    wire signed [SEQ_W-1:0] seqRe = SEQ_W'(phRe[0])
                                  - ((SEQ_W'(phRe[1]) + SEQ_W'(phRe[2])) >>> 1)
                                  + SEQ_W'(rotRe >>> unb_pkg::COEF_FRAC);
    wire signed [SEQ_W-1:0] seqIm = SEQ_W'(phIm[0])
                                  - ((SEQ_W'(phIm[1]) + SEQ_W'(phIm[2])) >>> 1)
                                  + SEQ_W'(rotIm >>> unb_pkg::COEF_FRAC);
    // downshift keeps the square in 32 bits; loses resolution on tiny currents
    wire signed [15:0] redRe = 16'(seqRe >>> SQ_SHIFT);
    wire signed [15:0] redIm = 16'(seqIm >>> SQ_SHIFT);
    wire [32:0] magSqWide = 33'(redRe * redRe) + 33'(redIm * redIm);
    wire [unb_pkg::SQ_W-1:0] magSq = magSqWide[32] ? '1 : magSqWide[31:0];

    // qualification of the function
    wire active   = configEnabled && (functionMode != unb_pkg::UNB_MODE_OFF);
    wire clearAll = !active || blkSync_q;
    wire clearTh  = clearAll || clrSync_q;
    wire tripAllowed = functionMode == unb_pkg::UNB_MODE_ON;

    // stage pickups on the new magnitude
    wire permPk = magSq > permissibleUnbalanceThreshold;
    wire highPk = magSq > highUnbalanceThreshold;

    // warning and high-set definite-time counters
    logic [unb_pkg::TICK_W-1:0] warnCnt_q, highCnt_q;
    wire [unb_pkg::TICK_W-1:0] warnCntD = !permPk ? '0 :
        (warnCnt_q < warnDelay) ? warnCnt_q + 24'h1 : warnCnt_q;
    wire [unb_pkg::TICK_W-1:0] highCntD = !highPk ? '0 :
        (highCnt_q < highStageDelay) ? highCnt_q + 24'h1 : highCnt_q;
    wire warnD = permPk && (warnCntD >= warnDelay);
    wire highTripD = highPk && (highCntD >= highStageDelay);

    // thermal image scaled by cool-down ticks, so cooling is exact
    logic [unb_pkg::ACC_W-1:0] acc_q;
    wire [unb_pkg::SQ_W+7:0] clampPerm = (unb_pkg::SQ_W+8)'(permissibleUnbalanceThreshold
                                         * unb_pkg::CLAMP_FACTOR_SQ);
    wire [unb_pkg::SQ_W+7:0] clampLim  = (clampPerm < (unb_pkg::SQ_W+8)'(highUnbalanceThreshold))
                                         ? clampPerm : (unb_pkg::SQ_W+8)'(highUnbalanceThreshold);
    wire [unb_pkg::SQ_W+7:0] clampedSq = ((unb_pkg::SQ_W+8)'(magSq) > clampLim)
                                         ? clampLim : (unb_pkg::SQ_W+8)'(magSq);
    wire [unb_pkg::ACC_W-1:0] heat = unb_pkg::ACC_W'(clampedSq * coolDownTime);
    wire [unb_pkg::ACC_W-1:0] tripLevel = unb_pkg::ACC_W'(PROD_W'(asymmetryFactor)
                                          * PROD_W'(coolDownTime));
    wire [unb_pkg::ACC_W-1:0] ceiling = tripLevel << unb_pkg::CEILING_SHIFT;
    wire [unb_pkg::ACC_W-1:0] heated  = acc_q + heat;
    wire [unb_pkg::ACC_W-1:0] coolStep = unb_pkg::ACC_W'(asymmetryFactor);
    wire [unb_pkg::ACC_W-1:0] accHeat = (heated > ceiling) ? ceiling : heated;
    wire [unb_pkg::ACC_W-1:0] accCool = (acc_q > coolStep) ? acc_q - coolStep : '0;
    wire [unb_pkg::ACC_W-1:0] accD = permPk ? accHeat : accCool;
    wire thermTripD = permPk && (accD >= tripLevel);

    // pickups and timers advance on the tick only
    always_ff @(posedge clk) begin
        if (rst || clearAll) begin
            warnCnt_q <= '0;
            highCnt_q <= '0;
        end else if (tick_q) begin
            warnCnt_q <= warnCntD;
            highCnt_q <= highCntD;
        end
    end

    // thermal image; clear from block or clear input overrides a tick
    always_ff @(posedge clk) begin
        if (rst || clearTh) acc_q <= '0;
        else if (tick_q) acc_q <= accD;
    end

    // stage indications, dropped at once by block or inactivity
    always_ff @(posedge clk) begin
        if (rst || clearAll) begin
            permPickup           <= 1'b0;
            highPickup           <= 1'b0;
            unbalanceWarningFlag <= 1'b0;
            thermalTrip          <= 1'b0;
            highStageTrip        <= 1'b0;
        end else if (tick_q) begin
            permPickup           <= permPk;
            highPickup           <= highPk;
            unbalanceWarningFlag <= warnD;
            thermalTrip          <= thermTripD;
            highStageTrip        <= highTripD;
        end
    end

    // trip command only in the on position; inhibit still indicates
    always_ff @(posedge clk) begin
        if (rst || clearAll) tripCommand <= 1'b0;
        else if (tick_q) tripCommand <= tripAllowed && (thermTripD || highTripD);
    end

    // status and measured value
    always_ff @(posedge clk) begin
        if (rst) begin
            functionActive <= 1'b0;
            negSeqSquared  <= '0;
        end else begin
            functionActive <= active;
            if (tick_q) negSeqSquared <= magSq;
        end
    end

endmodule : unb_negseq_prot

`default_nettype wire

/* unb_negseq_prot_asserts.sv */
// Purpose: port-level checks on the negative-sequence protection block
// Assumes: the mode only changes while the trip outputs are cleared
// Notes:   binary inputs cost two sync edges plus one clearing edge
`timescale 1ns/1ps
`default_nettype none
module unb_negseq_prot_asserts (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // controls
    input wire logic               functionBlockInput,
    input wire logic               configEnabled,
    input wire unb_pkg::unb_mode_e functionMode,
    // indications
    input wire logic               functionActive,
    input wire logic               permPickup,
    input wire logic               highPickup,
    input wire logic               unbalanceWarningFlag,
    input wire logic               thermalTrip,
    input wire logic               highStageTrip,
    input wire logic               tripCommand
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // command only in the on position, and only from a stage trip
    cmd_mode_a: assert property (tripCommand |-> functionMode == unb_pkg::UNB_MODE_ON)
        else $error("trip command outside on mode");
    cmd_source_a: assert property (tripCommand |-> thermalTrip || highStageTrip)
        else $error("trip command without a stage trip");
    // stage outputs never stand without their pickup
    therm_pick_a: assert property (thermalTrip |-> permPickup)
        else $error("thermal trip without pickup");
    high_pick_a: assert property (highStageTrip |-> highPickup)
        else $error("high stage trip without pickup");
    warn_pick_a: assert property (unbalanceWarningFlag |-> permPickup)
        else $error("warning without pickup");
    // activity follows configuration and switch one clock late
    active_cfg_a: assert property (!$past(rst) |-> functionActive ==
        $past(configEnabled && functionMode != unb_pkg::UNB_MODE_OFF))
        else $error("active flag does not follow configuration");
    inactive_quiet_a: assert property ((!configEnabled)[*4] |-> !functionActive && !permPickup)
        else $error("unconfigured function still picks up");
    block_clear_a: assert property (functionBlockInput[*4] |->
        !permPickup && !highPickup && !thermalTrip && !unbalanceWarningFlag)
        else $error("block input left an indication standing");
endmodule : unb_negseq_prot_asserts
bind unb_negseq_prot unb_negseq_prot_asserts u_unb_negseq_prot_asserts (
    .clk(clk), .rst(rst), .functionBlockInput(functionBlockInput),
    .configEnabled(configEnabled), .functionMode(functionMode),
    .functionActive(functionActive), .permPickup(permPickup), .highPickup(highPickup),
    .unbalanceWarningFlag(unbalanceWarningFlag), .thermalTrip(thermalTrip),
    .highStageTrip(highStageTrip), .tripCommand(tripCommand));
`default_nettype wire

/* unb_phase_source.sv */
// Purpose: phase current source giving a pure counter-rotating wave
// Assumes: one sample triple every clock once out of reset
// Notes:   amp is taken per sample, so change it only on a cycleDone edge
`timescale 1ns/1ps
`default_nettype none
module unb_phase_source (
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                rst,
    // wave amplitude
    input  wire logic signed [unb_pkg::SAMPLE_W-1:0] amp,
    // sample stream
    output logic                                     sampleValid,
    output logic signed [unb_pkg::SAMPLE_W-1:0]      sampleA,
    output logic signed [unb_pkg::SAMPLE_W-1:0]      sampleB,
    output logic signed [unb_pkg::SAMPLE_W-1:0]      sampleC,
    output logic                                     cycleDone
);
    logic [3:0] idx_q;
    // phase b leads a by 120 degrees, the counter-rotating system
    function automatic logic signed [15:0] wave(input int k);
        logic signed [24:0] p;
        p = amp * unb_pkg::COS_TAB[k % 12];
        return p[23:8];
    endfunction : wave
    // cycleDone is seen on the edge that presents the last sample
    always_ff @(posedge clk) begin
        if (rst) begin
            idx_q       <= 4'h0;
            sampleValid <= 1'b0;
            cycleDone   <= 1'b0;
        end else begin
            sampleValid <= 1'b1;
            sampleA     <= wave(idx_q);
            sampleB     <= wave(idx_q + 4);
            sampleC     <= wave(idx_q + 8);
            idx_q       <= (idx_q == 4'hB) ? 4'h0 : idx_q + 4'h1;
            cycleDone   <= (idx_q == 4'hA);
        end
    end
endmodule : unb_phase_source
`default_nettype wire

/* unb_pkg.sv */
// Purpose: shared constants and types for the negative-sequence protection block
// Assumes: 12 samples per power cycle, one protection tick per completed cycle
// Notes:   squared quantities are raw magnitude-squared units of 3*I2 after downshift
package unb_pkg;

    // function switch positions
    typedef enum logic [1:0] {
        UNB_MODE_OFF,
        UNB_MODE_ON,
        UNB_MODE_TRIP_INHIBIT
    } unb_mode_e;

    // sampling and DFT
    localparam int SAMPLES_PER_CYCLE = 12;
    localparam int SAMPLE_W          = 16;
    localparam int COEF_W            = 9;
    localparam int COEF_FRAC         = 8;
    localparam int IDX_W             = 4;
    localparam logic [IDX_W-1:0] LAST_SAMPLE_IDX = 4'hB;
    localparam logic [IDX_W-1:0] FIRST_SAMPLE_IDX = 4'h0;

    // cosine and sine of k*30 degrees, scaled by 256
    localparam logic signed [COEF_W-1:0] COS_TAB [0:SAMPLES_PER_CYCLE-1] = '{
        9'sh100, 9'sh0DE, 9'sh080, 9'sh000, -9'sh080, -9'sh0DE,
        -9'sh100, -9'sh0DE, -9'sh080, 9'sh000, 9'sh080, 9'sh0DE};
    localparam logic signed [COEF_W-1:0] SIN_TAB [0:SAMPLES_PER_CYCLE-1] = '{
        9'sh000, 9'sh080, 9'sh0DE, 9'sh100, 9'sh0DE, 9'sh080,
        9'sh000, -9'sh080, -9'sh0DE, -9'sh100, -9'sh0DE, -9'sh080};

    // sqrt(3)/2 scaled by 256, the imaginary part of the rotation operator
    localparam logic signed [COEF_W-1:0] ROT_IM_Q8 = 9'sh0DE;

    // thermal clamp: 10 x permissible current, i.e. 100 x in the squared domain
    localparam logic [7:0] CLAMP_FACTOR_SQ = 8'h64;
    // thermal memory ceiling is twice the trip level
    localparam int CEILING_SHIFT = 1;

    // widths of settings and state
    localparam int SQ_W    = 32;
    localparam int TICK_W  = 24;
    localparam int ACC_W   = 64;

endpackage : unb_pkg
